//--- core/ifp_pkg.sv
package ifp_pkg;
	localparam int PC_W      = 21;
	localparam int INSN_W    = 16;
	localparam int DADDR_W   = 12;
	localparam int SP_W      = 5;
	localparam int REL_W     = 11;
	localparam logic [PC_W-1:0] PC_RESET  = 21'h000000;
	localparam logic [PC_W-1:0] VEC_HIGH  = 21'h000008;
	localparam logic [PC_W-1:0] VEC_LOW   = 21'h000018;
	localparam logic [PC_W-1:0] PC_STEP   = 21'h000002;
	localparam logic [SP_W-1:0] SP_RESET  = 5'h00;
	localparam logic [SP_W-1:0] SP_STEP   = 5'h01;
	localparam logic [INSN_W-1:0] NOP_WORD = 16'h0000;

	// Quarter phases of one instruction cycle
	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} ifp_phase_t;

	// Program counter change requested by the execute unit
	typedef enum logic [1:0] {
		BR_NONE = 2'h0,
		BR_ABS  = 2'h1,
		BR_REL  = 2'h2
	} ifp_branch_t;
endpackage

//--- core/ifp_phase_gen.sv
`timescale 1ns/1ps
module ifp_phase_gen (
	input  wire logic               core_clk,
	input  wire logic               rstn,
	output ifp_pkg::ifp_phase_t     phase
);
	import ifp_pkg::*;

	typedef struct packed {
		ifp_phase_t ph;
	} ifp_pg_state_t;

	ifp_pg_state_t st_reg;
	ifp_pg_state_t st_next;

	// Rotate one phase per clock; reset lands on the last phase
	always_comb begin
		st_next = st_reg;
		unique case (st_reg.ph)
			PH_Q1: st_next.ph = PH_Q2;
			PH_Q2: st_next.ph = PH_Q3;
			PH_Q3: st_next.ph = PH_Q4;
			PH_Q4: st_next.ph = PH_Q1;
			default: st_next.ph = PH_Q1;
		endcase
		if (!rstn) begin
			st_next.ph = PH_Q4;
		end
	end

	always_ff @(posedge core_clk) begin
		st_reg <= st_next;
	end

	assign phase = st_reg.ph;
endmodule // ifp_phase_gen

//--- core/ifp_pipeline.sv
`timescale 1ns/1ps
module ifp_pipeline (
	input  wire logic                        core_clk,
	input  wire logic                        rstn,
	// Program memory, byte addressed
	output logic [ifp_pkg::PC_W-1:0]         pmem_addr,
	output logic                             pmem_rd,
	input  wire logic [7:0]                  pmem_lo_byte,
	input  wire logic [7:0]                  pmem_hi_byte,
	// Holding register and phase to the execute unit
	output logic [ifp_pkg::INSN_W-1:0]       instruction_holding_register,
	output logic                             insn_valid,
	output logic [3:0]                       phase_out,
	// Execute unit requests
	input  wire ifp_pkg::ifp_branch_t        exe_branch,
	input  wire logic [ifp_pkg::PC_W-2:0]    exe_abs_word,
	input  wire logic [ifp_pkg::REL_W-1:0]   exe_rel_words,
	input  wire logic [ifp_pkg::DADDR_W-1:0] exe_src_addr,
	input  wire logic [ifp_pkg::DADDR_W-1:0] exe_dst_addr,
	input  wire logic                        exe_dst_we,
	input  wire logic [7:0]                  exe_dst_data,
	// Data memory
	output logic [ifp_pkg::DADDR_W-1:0]      dmem_addr,
	output logic                             dmem_rd,
	output logic                             dmem_wr,
	output logic [7:0]                       dmem_wdata,
	// Interrupt wake
	input  wire logic                        wake_irq,
	input  wire logic                        wake_high_prio,
	input  wire logic                        high_priority_global_irq_enable,
	input  wire logic                        low_priority_global_irq_enable,
	// Hardware stack top
	output logic [7:0]                       stack_top_upper_byte,
	output logic [7:0]                       stack_top_high_byte,
	output logic [7:0]                       stack_top_low_byte,
	output logic [ifp_pkg::SP_W-1:0]         hardware_stack_pointer,
	output logic                             pc_bit0
);
	import ifp_pkg::*;

	typedef struct packed {
		logic [PC_W-1:0]    pc;
		logic [INSN_W-1:0]  fetched;
		logic               fetched_ok;
		logic [INSN_W-1:0]  ir;
		logic               ir_ok;
		logic               flush;
		logic [PC_W-1:0]    pc_new;
		logic               pc_load;
		logic [23:0]        tos;
		logic [SP_W-1:0]    sp;
		logic [DADDR_W-1:0] daddr;
		logic               drd;
		logic               dwr;
		logic [7:0]         dwdata;
		logic               prd;
	} ifp_state_t;

	ifp_state_t         st_reg;
	ifp_state_t         st_next;
	ifp_phase_t         phase;
	logic               wake_take;
	logic [PC_W-1:0]    vec;
	logic [PC_W-1:0]    rel_bytes;

	ifp_phase_gen u_phase (
		.core_clk (core_clk),
		.rstn     (rstn),
		.phase    (phase)
	);

	// Wake vectors only when a global enable level is set
	assign wake_take = wake_irq && (high_priority_global_irq_enable ||
		low_priority_global_irq_enable);
	assign vec = wake_high_prio ? VEC_HIGH : VEC_LOW;
	// Word offset sign-extended then doubled into bytes
	assign rel_bytes = {{(PC_W-REL_W-1){exe_rel_words[REL_W-1]}},
		exe_rel_words, 1'b0};

	always_comb begin
		st_next = st_reg;
		st_next.drd = 1'b0;
		st_next.dwr = 1'b0;
		st_next.prd = 1'b0;
		unique case (phase)
			PH_Q1: begin
				// Fetched word moves to execute while the PC steps on
				st_next.ir = st_reg.fetched;
				st_next.ir_ok = st_reg.fetched_ok && !st_reg.flush;
				st_next.flush = 1'b0;
				if (st_reg.pc_load) begin
					st_next.pc = st_reg.pc_new;
					st_next.pc_load = 1'b0;
				end else begin
					st_next.pc = st_reg.pc + PC_STEP;
				end
				st_next.pc[0] = 1'b0;
			end
			PH_Q2: begin
				st_next.daddr = exe_src_addr;
				st_next.drd = st_reg.ir_ok;
				st_next.prd = 1'b1;
			end
			PH_Q3: begin
				// Even byte is the low half of the word
				st_next.fetched = {pmem_hi_byte, pmem_lo_byte};
				st_next.fetched_ok = 1'b1;
				if (st_reg.ir_ok && exe_branch == BR_ABS) begin
					st_next.pc_new = {exe_abs_word, 1'b0};
					st_next.pc_load = 1'b1;
					st_next.flush = 1'b1;
				end else if (st_reg.ir_ok && exe_branch == BR_REL) begin
					st_next.pc_new = st_reg.pc + rel_bytes;
					st_next.pc_load = 1'b1;
					st_next.flush = 1'b1;
				end
			end
			PH_Q4: begin
				st_next.daddr = exe_dst_addr;
				st_next.dwr = st_reg.ir_ok && exe_dst_we;
				st_next.dwdata = exe_dst_data;
				// Wake push takes priority over a branch in the same cycle
				if (wake_take) begin
					st_next.tos = {3'h0, st_reg.pc};
					st_next.sp = st_reg.sp + SP_STEP;
					st_next.pc_new = vec;
					st_next.pc_load = 1'b1;
					st_next.flush = 1'b1;
				end
			end
		endcase
		if (!rstn) begin
			st_next = '0;
			st_next.pc = PC_RESET;
			st_next.sp = SP_RESET;
			st_next.fetched = NOP_WORD;
			st_next.ir = NOP_WORD;
		end
	end

	always_ff @(posedge core_clk) begin
		st_reg <= st_next;
	end

	// Byte address is the PC itself; both bytes return together
	assign pmem_addr = st_reg.pc;
	assign pmem_rd = st_reg.prd;
	assign instruction_holding_register = st_reg.ir;
	assign insn_valid = st_reg.ir_ok;
	assign phase_out = phase;
	assign dmem_addr = st_reg.daddr;
	assign dmem_rd = st_reg.drd;
	assign dmem_wr = st_reg.dwr;
	assign dmem_wdata = st_reg.dwdata;
	assign stack_top_upper_byte = st_reg.tos[23:16];
	assign stack_top_high_byte = st_reg.tos[15:8];
	assign stack_top_low_byte = st_reg.tos[7:0];
	assign hardware_stack_pointer = st_reg.sp;
	assign pc_bit0 = st_reg.pc[0];
endmodule // ifp_pipeline

//--- tb/ifp_pipeline_sva.sv
`timescale 1ns/1ps
module ifp_pipeline_sva (
	input wire logic        core_clk,
	input wire logic        rstn,
	input wire logic [20:0] pmem_addr,
	input wire logic        pmem_rd,
	input wire logic [15:0] instruction_holding_register,
	input wire logic [3:0]  phase_out,
	input wire logic        exe_dst_we,
	input wire logic        dmem_rd,
	input wire logic        dmem_wr,
	input wire logic [4:0]  hardware_stack_pointer,
	input wire logic        insn_valid,
	input wire logic        pc_bit0
);
	wire [15:0] ir = instruction_holding_register;
	wire [4:0]  sp = hardware_stack_pointer;
	// All checks sleep through reset
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);
	a_phase_wrap: assert property (phase_out[3] |=> phase_out[0])
		else $error("phase ring");
	a_fetch_slot: assert property (pmem_rd == phase_out[2])
		else $error("fetch slot");
	a_pc_even: assert property (!pc_bit0 && !pmem_addr[0])
		else $error("odd pc");
	// One step per cycle, so a mid-cycle change is a slip
	a_pc_hold: assert property ($changed(pmem_addr) |=>
		$stable(pmem_addr)[*3]) else $error("pc moved");
	a_ir_hold: assert property ($changed(ir) |=> $stable(ir)[*3])
		else $error("ir moved");
	a_read_slot: assert property (dmem_rd |-> phase_out[2])
		else $error("read slot");
	a_write_cause: assert property (dmem_wr |->
		$past(exe_dst_we) ##1 !dmem_wr) else $error("stray write");
	a_sp_step: assert property ($changed(sp) |->
		sp == $past(sp) + 5'h01) else $error("sp step");
	c_write: cover property (dmem_wr);
	c_flush: cover property (phase_out[0] && !insn_valid);
	c_wake: cover property ($changed(sp));
endmodule // ifp_pipeline_sva

bind ifp_pipeline ifp_pipeline_sva u_sva (.*);

//--- tb/ifp_mem_model.sv
`timescale 1ns/1ps
module ifp_mem_model (
	input  wire logic        core_clk,
	input  wire logic [20:0] pmem_addr,
	input  wire logic        pmem_rd,
	output logic [7:0]       pmem_lo_byte,
	output logic [7:0]       pmem_hi_byte,
	input  wire logic [11:0] dmem_addr,
	input  wire logic        dmem_wr,
	input  wire logic [7:0]  dmem_wdata,
	output int               wr_n,
	output logic [19:0]      wr_ad
);
	function automatic logic [7:0] mb(input logic [20:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h3c;
	endfunction
	// Bytes invert outside the read slot so stale data is never trusted
	assign pmem_lo_byte = mb(pmem_addr) ^ {8{!pmem_rd}};
	assign pmem_hi_byte = mb(pmem_addr | 21'h1) ^ {8{!pmem_rd}};
	// Log each write strobe
	initial wr_n = 0;
	always @(posedge core_clk) if (dmem_wr) begin
		wr_n <= wr_n + 1;
		wr_ad <= {dmem_addr, dmem_wdata};
	end
endmodule // ifp_mem_model

//--- tb/tb_ifp_pipeline.sv
`timescale 1ns/1ps
module tb_ifp_pipeline;
	import ifp_pkg::*;
	logic [20:0] pmem_addr, xpc, opc;
	logic [15:0] instruction_holding_register;
	logic [11:0] exe_src_addr, exe_dst_addr, dmem_addr;
	logic [19:0] exe_abs_word, wr_ad, xwr;
	logic [10:0] exe_rel_words;
	logic [7:0]  pmem_lo_byte, pmem_hi_byte, exe_dst_data, dmem_wdata;
	logic [7:0]  stack_top_upper_byte, stack_top_high_byte, stack_top_low_byte;
	logic [4:0]  hardware_stack_pointer, xsp;
	logic [3:0]  phase_out;
	logic [31:0] r = 32'h04c993da;
	logic        core_clk = 1'b0, rstn = 1'b0, exe_dst_we = 1'b0;
	logic        wake_irq = 1'b0, wake_high_prio = 1'b0;
	logic        high_priority_global_irq_enable = 1'b0;
	logic        low_priority_global_irq_enable = 1'b0;
	logic        pmem_rd, insn_valid, dmem_rd, dmem_wr, pc_bit0, xv, tw;
	ifp_branch_t exe_branch = BR_NONE;
	int          err_total = 0, tests_run = 0, wr_n, xwn = 0, i, k;
	wire [23:0]  tos = {stack_top_upper_byte, stack_top_high_byte,
		stack_top_low_byte};
	ifp_pipeline dut (.*);
	ifp_mem_model mem (.*);
	always #5 core_clk = ~core_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic [23:0] g, input logic [23:0] e);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", err_total, tests_run);
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// About 1020 clocks are needed; a hang stops well beyond that
	initial begin
		repeat (4000) @(posedge core_clk);
		err_total++;
		test_done;
	end
	// One random instruction cycle per pass, requests held for all of it
	initial begin
		{exe_abs_word, exe_rel_words, exe_src_addr} = '0;
		{exe_dst_addr, exe_dst_data} = '0;
		repeat (12) @(negedge core_clk);
		rstn = 1'b1;
		xpc = PC_STEP;
		xv = 1'b0;
		xsp = SP_RESET;
		tw = 1'b0;
		for (i = 0; i < 251; i++) begin
			k = 0;
			// Look in Q2, after the Q1 edge has moved the PC and the
			// holding register, so both belong to the cycle now running
			do @(negedge core_clk); while (!phase_out[1] && ++k < 8);
			if (k >= 8)
				err_total++;
			chk(pmem_addr, xpc);
			chk(insn_valid, xv);
			if (xv) chk(instruction_holding_register,
				{mem.mb(xpc - 21'h1), mem.mb(xpc - 21'h2)});
			chk(hardware_stack_pointer, xsp);
			if (tw) chk(tos, {3'h0, opc});
			r = lfsr(r);
			opc = xpc;
			exe_branch = ifp_branch_t'(r[1] ? 2'h2 : {1'b0, r[0]});
			exe_abs_word = (i == 3) ? 20'hfffff : r[31:12];
			exe_rel_words = (i == 5) ? 11'h400 : r[22:12];
			wake_irq = r[4:2] == 3'h0 && i < 250;
			wake_high_prio = r[5];
			high_priority_global_irq_enable = r[6];
			low_priority_global_irq_enable = r[7];
			exe_src_addr = r[19:8];
			exe_dst_addr = r[27:16];
			exe_dst_data = r[15:8];
			exe_dst_we = r[8] && i < 250;
			tw = wake_irq && r[7:6] != 2'h0;
			if (xv && exe_dst_we) begin
				xwn++;
				xwr = {exe_dst_addr, exe_dst_data};
			end
			xsp = xsp + 5'(tw);
			if (tw)
				xpc = wake_high_prio ? VEC_HIGH : VEC_LOW;
			else if (xv && exe_branch == BR_ABS)
				xpc = {exe_abs_word, 1'b0};
			else if (xv && exe_branch == BR_REL)
				xpc = xpc + {{9{exe_rel_words[10]}}, exe_rel_words, 1'b0};
			else
				xpc = xpc + PC_STEP;
			xv = !(tw || (xv && exe_branch != BR_NONE));
		end
		repeat (8) @(negedge core_clk);
		chk(wr_n[23:0], xwn[23:0]);
		chk(wr_ad, xwr);
		test_done;
	end
endmodule // tb_ifp_pipeline
